// >>> rtl/cal_map.svh
// Register offsets, field positions, reset values and bus codes of the arithmetic datapath
`ifndef CAL_MAP_SVH
`define CAL_MAP_SVH
`define CAL_ADDR_W 12
`define CAL_ACC_OFS 12'h000
`define CAL_STATUS_OFS 12'h004
`define CAL_PTR0_OFS 12'h008
`define CAL_PTR1_OFS 12'h00c
`define CAL_RESULT_OFS 12'h010
`define CAL_COUNT_OFS 12'h014
`define CAL_FILE_BASE 12'h200
`define CAL_FILE_LAST 12'h3fc
`define CAL_C_BIT 0
`define CAL_NIB_BIT 1
`define CAL_Z_BIT 2
`define CAL_DEST_BIT 8
`define CAL_ACC_RST 8'h00
`define CAL_PTR_RST 16'h0000
`define CAL_FILE_WORDS 128
`define CAL_RESP_OKAY 2'h0
`define CAL_RESP_SLVERR 2'h2
`endif

// >>> rtl/cal_pkg.sv
// Types shared by the arithmetic datapath files
package cal_pkg;
   typedef enum logic [2:0] {
      pointer_add_literal,
      and_literal_acc,
      add_literal_acc,
      and_acc_reg,
      add_acc_reg,
      arith_shift_right,
      add_with_carry_in
   } cal_op_t;

   typedef struct packed {
      cal_op_t op;
      logic [7:0] lit;
      logic [6:0] addr;
      logic dest;
      logic ptr_sel;
   } cal_instr_t;

   typedef struct packed {
      logic [7:0] result;
      logic [15:0] ptr_sum;
      logic c;
      logic nibble_out_bit;
      logic z;
      logic upd_c;
      logic upd_nib;
      logic upd_z;
      logic reg_op;
      logic ptr_op;
   } cal_alu_out_t;

   typedef struct packed {
      logic awvalid;
      logic [11:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [11:0] araddr;
      logic rready;
   } cal_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } cal_axi_rsp_t;

   typedef enum logic [2:0] {
      sel_acc,
      sel_status,
      sel_ptr0,
      sel_ptr1,
      sel_result,
      sel_count,
      sel_file,
      sel_none
   } cal_sel_t;
endpackage

// >>> rtl/cal_alu.sv
// Combinational result and flag logic of the arithmetic datapath
`timescale 1ns/1ns
`default_nettype none
module cal_alu
   import cal_pkg::*;
(
   input wire cal_instr_t instr_in,
   input wire logic [7:0] acc_in,
   input wire logic [7:0] operand_in,
   input wire logic carry_in,
   input wire logic [15:0] ptr_in,
   output cal_alu_out_t alu_out
);
   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [7:0] addend;
   logic cin;

   always_comb begin
      addend = operand_in;
      cin = 1'b0;
      if (instr_in.op == add_literal_acc) begin
         addend = instr_in.lit;
      end
      if (instr_in.op == add_with_carry_in) begin
         cin = carry_in;
      end
      sum = {1'b0, acc_in} + {1'b0, addend} + {8'h00, cin};
      low_sum = {1'b0, acc_in[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
      alu_out = '0;
      // Sign extension keeps the sum modulo 65536
      alu_out.ptr_sum = ptr_in + {{10{instr_in.lit[5]}}, instr_in.lit[5:0]};
      unique case (instr_in.op)
         pointer_add_literal: begin
            alu_out.ptr_op = 1'b1;
         end
         and_literal_acc: begin
            alu_out.result = acc_in & instr_in.lit;
            alu_out.upd_z = 1'b1;
         end
         and_acc_reg: begin
            alu_out.result = acc_in & operand_in;
            alu_out.upd_z = 1'b1;
            alu_out.reg_op = 1'b1;
         end
         add_literal_acc, add_acc_reg, add_with_carry_in: begin
            alu_out.result = sum[7:0];
            alu_out.c = sum[8];
            alu_out.nibble_out_bit = low_sum[4];
            alu_out.upd_c = 1'b1;
            alu_out.upd_nib = 1'b1;
            alu_out.upd_z = 1'b1;
            alu_out.reg_op = (instr_in.op != add_literal_acc);
         end
         arith_shift_right: begin
            alu_out.result = {operand_in[7], operand_in[7:1]};
            alu_out.c = operand_in[0];
            alu_out.upd_c = 1'b1;
            alu_out.upd_z = 1'b1;
            alu_out.reg_op = 1'b1;
         end
         // Unused code 7 updates no flags but loads zero into the accumulator
         default: begin
            alu_out.result = 8'h00;
         end
      endcase
      alu_out.z = (alu_out.result == 8'h00);
   end
endmodule
`default_nettype wire

// >>> rtl/cal_core.sv
// Arithmetic datapath subset with file memory and AXI4-Lite register access
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "cal_map.svh"
// Functional notes
// - Pointer add: signed 6-bit literal, no flags
// - Pointer pair wraps modulo 65536
// - AND literal into accumulator, zero only
// - Add literal into accumulator, carry nibble zero
// - AND accumulator with register, zero only
// - Add accumulator and register, carry nibble zero
// - Destination bit of register operations: 0 accumulator, 1 register
// - Shift right keeps MSB, LSB to carry
// - Add accumulator, register and carry flag
module cal_core
   import cal_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic instr_valid_in,
   input wire cal_instr_t instr_in,
   input wire cal_axi_req_t axi_req_in,
   output cal_axi_rsp_t axi_rsp_out,
   output logic [7:0] acc_out,
   output logic [2:0] flags_out,
   output logic [15:0] ptr0_out,
   output logic [15:0] ptr1_out,
   output logic done_out
);
   typedef struct packed {
      logic aw_got;
      logic [11:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] acc;
      logic [2:0] flags;
      logic [1:0][15:0] ptr;
      logic [8:0] result;
      logic [15:0] count;
      logic done;
   } cal_state_t;

   cal_state_t state;
   cal_state_t next_state;
   logic [7:0] file_mem [`CAL_FILE_WORDS];
   cal_alu_out_t alu_res;
   logic [7:0] operand;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic aw_hs;
   logic w_hs;
   logic wr_commit;
   logic ar_hs;
   cal_sel_t wr_sel;
   cal_sel_t rd_sel;
   logic mem_we_bus;
   logic mem_we_ins;
   logic [6:0] mem_bus_idx;
   logic [7:0] mem_bus_data;
   logic [7:0] ins_data;

   // Word-aligned address decode shared by reads and writes
   function automatic cal_sel_t decode_addr(input logic [11:0] addr);
      cal_sel_t sel;
      sel = sel_none;
      if (addr[1:0] == 2'h0) begin
         if (addr == `CAL_ACC_OFS) begin
            sel = sel_acc;
         end else if (addr == `CAL_STATUS_OFS) begin
            sel = sel_status;
         end else if (addr == `CAL_PTR0_OFS) begin
            sel = sel_ptr0;
         end else if (addr == `CAL_PTR1_OFS) begin
            sel = sel_ptr1;
         end else if (addr == `CAL_RESULT_OFS) begin
            sel = sel_result;
         end else if (addr == `CAL_COUNT_OFS) begin
            sel = sel_count;
         end else if (addr >= `CAL_FILE_BASE && addr <= `CAL_FILE_LAST) begin
            sel = sel_file;
         end
      end
      return sel;
   endfunction

   // The 7-bit field picks one of 128 locations
   assign operand = file_mem[instr_in.addr];

   cal_alu u_alu (
      .instr_in(instr_in),
      .acc_in(state.acc),
      .operand_in(operand),
      .carry_in(state.flags[`CAL_C_BIT]),
      .ptr_in(state.ptr[instr_in.ptr_sel]),
      .alu_out(alu_res)
   );

   assign aw_hs = axi_req_in.awvalid && !state.aw_got && !state.bvalid;
   assign w_hs = axi_req_in.wvalid && !state.w_got && !state.bvalid;
   assign wr_addr = state.aw_got ? state.aw_addr : axi_req_in.awaddr;
   assign wr_data = state.w_got ? state.w_data : axi_req_in.wdata;
   assign wr_strb = state.w_got ? state.w_strb : axi_req_in.wstrb;
   assign wr_commit = (state.aw_got || aw_hs) && (state.w_got || w_hs);
   assign ar_hs = axi_req_in.arvalid && !state.rvalid;
   assign wr_sel = decode_addr(wr_addr);
   assign rd_sel = decode_addr(axi_req_in.araddr);
   assign mem_bus_idx = wr_addr[8:2];
   assign mem_bus_data = wr_data[7:0];
   assign mem_we_bus = wr_commit && (wr_sel == sel_file) && wr_strb[0];
   // Register-operand results go back to memory when destination is set
   assign mem_we_ins = instr_valid_in && alu_res.reg_op && instr_in.dest;
   assign ins_data = alu_res.result;

   always_comb begin
      next_state = state;
      next_state.done = 1'b0;
      if (aw_hs) begin
         next_state.aw_got = 1'b1;
         next_state.aw_addr = axi_req_in.awaddr;
      end
      if (w_hs) begin
         next_state.w_got = 1'b1;
         next_state.w_data = axi_req_in.wdata;
         next_state.w_strb = axi_req_in.wstrb;
      end
      if (state.bvalid && axi_req_in.bready) begin
         next_state.bvalid = 1'b0;
      end
      if (wr_commit) begin
         next_state.aw_got = 1'b0;
         next_state.w_got = 1'b0;
         next_state.bvalid = 1'b1;
         next_state.bresp = `CAL_RESP_OKAY;
         unique case (wr_sel)
            sel_acc: begin
               if (wr_strb[0]) begin
                  next_state.acc = wr_data[7:0];
               end
            end
            sel_status: begin
               if (wr_strb[0]) begin
                  next_state.flags = wr_data[2:0];
               end
            end
            sel_ptr0, sel_ptr1: begin
               for (int b = 0; b < 2; b++) begin
                  if (wr_strb[b]) begin
                     next_state.ptr[wr_sel == sel_ptr1][b*8 +: 8] = wr_data[b*8 +: 8];
                  end
               end
            end
            sel_file, sel_result, sel_count: begin
               next_state.bresp = `CAL_RESP_OKAY;
            end
            sel_none: begin
               next_state.bresp = `CAL_RESP_SLVERR;
            end
         endcase
      end
      if (state.rvalid && axi_req_in.rready) begin
         next_state.rvalid = 1'b0;
      end
      if (ar_hs) begin
         next_state.rvalid = 1'b1;
         next_state.rresp = `CAL_RESP_OKAY;
         next_state.rdata = 32'h0000_0000;
         unique case (rd_sel)
            sel_acc: next_state.rdata[7:0] = state.acc;
            sel_status: next_state.rdata[2:0] = state.flags;
            sel_ptr0: next_state.rdata[15:0] = state.ptr[0];
            sel_ptr1: next_state.rdata[15:0] = state.ptr[1];
            sel_result: next_state.rdata[8:0] = state.result;
            sel_count: next_state.rdata[15:0] = state.count;
            sel_file: next_state.rdata[7:0] = file_mem[axi_req_in.araddr[8:2]];
            sel_none: next_state.rresp = `CAL_RESP_SLVERR;
         endcase
      end
      // Instruction applied after the bus write so hardware updates win
      if (instr_valid_in) begin
         next_state.done = 1'b1;
         next_state.count = state.count + 16'h0001;
         if (alu_res.ptr_op) begin
            next_state.ptr[instr_in.ptr_sel] = alu_res.ptr_sum;
         end else begin
            next_state.result = {alu_res.reg_op && instr_in.dest, alu_res.result};
            if (!(alu_res.reg_op && instr_in.dest)) begin
               next_state.acc = alu_res.result;
            end
            if (alu_res.upd_c) begin
               next_state.flags[`CAL_C_BIT] = alu_res.c;
            end
            if (alu_res.upd_nib) begin
               next_state.flags[`CAL_NIB_BIT] = alu_res.nibble_out_bit;
            end
            if (alu_res.upd_z) begin
               next_state.flags[`CAL_Z_BIT] = alu_res.z;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state <= '0;
         state.acc <= `CAL_ACC_RST;
         state.ptr <= {`CAL_PTR_RST, `CAL_PTR_RST};
      end else begin
         state <= next_state;
      end
   end

   // File memory is not reset; instruction write wins on a collision
   always_ff @(posedge sys_clk_in) begin
      if (mem_we_bus) begin
         file_mem[mem_bus_idx] <= mem_bus_data;
      end
      if (mem_we_ins) begin
         file_mem[instr_in.addr] <= ins_data;
      end
   end

   always_comb begin
      axi_rsp_out.awready = !state.aw_got && !state.bvalid;
      axi_rsp_out.wready = !state.w_got && !state.bvalid;
      axi_rsp_out.bvalid = state.bvalid;
      axi_rsp_out.bresp = state.bresp;
      axi_rsp_out.arready = !state.rvalid;
      axi_rsp_out.rvalid = state.rvalid;
      axi_rsp_out.rdata = state.rdata;
      axi_rsp_out.rresp = state.rresp;
   end

   assign acc_out = state.acc;
   assign flags_out = state.flags;
   assign ptr0_out = state.ptr[0];
   assign ptr1_out = state.ptr[1];
   assign done_out = state.done;
endmodule
`default_nettype wire

// >>> dv/cal_core_properties.sv
// Port-level checks of the arithmetic datapath
`timescale 1ns/1ns
`default_nettype none
module cal_core_properties
   import cal_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic instr_valid_in,
   input wire cal_instr_t instr_in,
   input wire cal_axi_req_t axi_req_in,
   input wire cal_axi_rsp_t axi_rsp_out,
   input wire logic [7:0] acc_out,
   input wire logic [2:0] flags_out,
   input wire logic [15:0] ptr0_out,
   input wire logic [15:0] ptr1_out,
   input wire logic done_out
);
   wire logic v = instr_valid_in;
   wire cal_op_t op = instr_in.op;
   wire logic [7:0] lit = instr_in.lit;
   // Zero flag must track whatever landed in the accumulator
   wire logic z_ok = flags_out[2] == (acc_out == 8'h00);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   ptr_add_a: assert property (v && op == pointer_add_literal && !instr_in.ptr_sel
      |=> ptr0_out == $past(ptr0_out) + {{10{$past(lit[5])}}, $past(lit[5:0])}) else $error("pointer sum");
   ptr_flags_a: assert property (v && op == pointer_add_literal
      |=> $stable(flags_out) && $stable(acc_out)) else $error("pointer add touched flags");
   and_lit_a: assert property (v && op == and_literal_acc
      |=> acc_out == ($past(acc_out) & $past(lit)) && z_ok && $stable(flags_out[1:0])) else $error("and literal");
   add_lit_a: assert property (v && op == add_literal_acc
      |=> {flags_out[0], acc_out} == 9'($past(acc_out)) + 9'($past(lit)) && z_ok) else $error("add literal");
   and_reg_a: assert property (v && op == and_acc_reg && !instr_in.dest
      |=> (acc_out & ~$past(acc_out)) == 8'h00 && z_ok && $stable(flags_out[1:0])) else $error("and register");
   dest_reg_a: assert property (v && instr_in.dest && op > add_literal_acc
      |-> ##1 $stable(acc_out)) else $error("file destination wrote accumulator");
   shift_keep_a: assert property (v && op == arith_shift_right && !instr_in.dest
      |=> acc_out[7] == acc_out[6] && z_ok && $stable(flags_out[1])) else $error("shift right");
   add_zero_a: assert property (v && (op == add_acc_reg || op == add_with_carry_in) && !instr_in.dest
      |=> z_ok) else $error("add register zero flag");
endmodule
bind cal_core cal_core_properties u_props (.sys_clk_in, .rst_in, .instr_valid_in, .instr_in, .axi_req_in,
   .axi_rsp_out, .acc_out, .flags_out, .ptr0_out, .ptr1_out, .done_out);
`default_nettype wire

// >>> dv/cal_issue_model.sv
// Decoder-side model issuing queued instructions, with stalls
`timescale 1ns/1ns
`default_nettype none
module cal_issue_model
   import cal_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic push_in,
   input wire cal_instr_t instr_in,
   input wire logic stall_in,
   output logic valid_out,
   output cal_instr_t instr_out
);
   cal_instr_t fifo[$];
   always @(posedge sys_clk_in) begin
      if (push_in) begin
         fifo.push_back(instr_in);
      end
      if (rst_in) begin
         valid_out <= 1'b0;
         instr_out <= '0;
      end else if (!stall_in && fifo.size() > 0) begin
         valid_out <= 1'b1;
         instr_out <= fifo.pop_front();
      end else begin
         valid_out <= 1'b0;
         // Idle fields flip so a stale operand is never reused
         instr_out <= cal_instr_t'(~instr_out);
      end
   end
endmodule
`default_nettype wire

// >>> dv/core_arith_logic_subset_tb.sv
// Self-checking bench for the arithmetic datapath against a reference model
`timescale 1ns/1ns
`default_nettype none
`include "cal_map.svh"
module core_arith_logic_subset_tb
   import cal_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, push = 1'b0, stall = 1'b0, chk = 1'b0, iv, done;
   cal_instr_t pin = '0, ins;
   cal_axi_req_t rq = '0;
   cal_axi_rsp_t rsp;
   logic [7:0] acc, m_acc = 8'h00;
   logic [2:0] fl, m_fl = 3'h0;
   logic [15:0] p0, p1, m_ptr[2] = '{16'h0000, 16'h0000};
   logic [31:0] seed = 32'haec8;
   logic [33:0] r;
   logic [7:0] m_mem[128];
   int err_total = 0, compares = 0, n_exec = 0;

   initial begin
      forever #2 clk = ~clk;
   end

   cal_issue_model i_issue (.sys_clk_in(clk), .rst_in(rst), .push_in(push), .instr_in(pin), .stall_in(stall),
      .valid_out(iv), .instr_out(ins));
   cal_core i_dut (.sys_clk_in(clk), .rst_in(rst), .instr_valid_in(iv), .instr_in(ins), .axi_req_in(rq),
      .axi_rsp_out(rsp), .acc_out(acc), .flags_out(fl), .ptr0_out(p0), .ptr1_out(p1), .done_out(done));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      if (err_total == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // One bus transfer; the idle edge first keeps ready releases apart
   task automatic axi(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      rq.awvalid <= w;
      rq.wvalid <= w;
      rq.bready <= w;
      rq.arvalid <= !w;
      rq.rready <= !w;
      rq.awaddr <= a;
      rq.araddr <= a;
      rq.wdata <= d;
      rq.wstrb <= 4'hf;
      do begin
         @(posedge clk);
         if (rsp.awready) rq.awvalid <= 1'b0;
         if (rsp.wready) rq.wvalid <= 1'b0;
         if (rsp.arready) rq.arvalid <= 1'b0;
      end while (!(w ? rsp.bvalid : rsp.rvalid));
      rq.bready <= 1'b0;
      rq.rready <= 1'b0;
      r = w ? {rsp.bresp, 32'h0} : {rsp.rresp, rsp.rdata};
   endtask

   task automatic push_one(input cal_instr_t i);
      pin <= i;
      push <= 1'b1;
      @(posedge clk);
   endtask

   task automatic step(input cal_instr_t i);
      logic [7:0] b, q;
      logic [8:0] s;
      logic cin, h;
      b = (i.op < and_acc_reg) ? i.lit : m_mem[i.addr];
      cin = (i.op == add_with_carry_in) & m_fl[0];
      s = m_acc + b + cin;
      h = ({1'b0, m_acc[3:0]} + {1'b0, b[3:0]} + cin) > 5'd15;
      q = s[7:0];
      case (i.op)
         pointer_add_literal: m_ptr[i.ptr_sel] += {{10{i.lit[5]}}, i.lit[5:0]};
         and_literal_acc, and_acc_reg: q = m_acc & b;
         arith_shift_right: begin
            q = {b[7], b[7:1]};
            m_fl[0] = b[0];
         end
         default: m_fl[1:0] = {h, s[8]};
      endcase
      if (i.op != pointer_add_literal) begin
         m_fl[2] = (q == 8'h00);
         if (i.dest && i.op > add_literal_acc) m_mem[i.addr] = q;
         else m_acc = q;
      end
   endtask

   always @(posedge clk) begin
      if (chk) check("state", {fl, acc, p1, p0, done}, {m_fl, m_acc, m_ptr[1], m_ptr[0], 1'b1});
      chk = iv && !rst;
      if (chk) begin
         step(ins);
         n_exec++;
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      tally_and_finish();
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("reset", {fl, acc, p1, p0}, 43'h0);
      for (int a = 0; a < `CAL_FILE_WORDS; a++) begin
         seed = xs(seed);
         m_mem[a] = seed[7:0];
         axi(1'b1, `CAL_FILE_BASE + 12'(a * 4), seed);
         check("file_wr", r, {`CAL_RESP_OKAY, 32'h0});
      end
      axi(1'b1, `CAL_PTR0_OFS, 32'hffff);
      axi(1'b1, `CAL_PTR1_OFS, 32'h001f);
      m_ptr = '{16'hffff, 16'h001f};
      axi(1'b1, 12'h100, 32'h5a);
      check("bad_wr", r, {`CAL_RESP_SLVERR, 32'h0});
      axi(1'b0, 12'h100, 32'h0);
      check("bad_rd", r, {`CAL_RESP_SLVERR, 32'h0});
      push_one(cal_instr_t'{pointer_add_literal, 8'h01, 7'h00, 1'b0, 1'b0});
      push_one(cal_instr_t'{pointer_add_literal, 8'h20, 7'h00, 1'b0, 1'b1});
      for (int k = 0; k < 400; k++) begin
         seed = xs(seed);
         stall <= seed[25];
         push_one(cal_instr_t'{cal_op_t'(seed[2:0] % 3'd7), seed[15:8], seed[22:16], seed[23], seed[24]});
      end
      push <= 1'b0;
      stall <= 1'b0;
      while (n_exec < 402) @(posedge clk);
      for (int a = 0; a < `CAL_FILE_WORDS; a++) begin
         axi(1'b0, `CAL_FILE_BASE + 12'(a * 4), 32'h0);
         check("file_rd", r, {`CAL_RESP_OKAY, 24'h0, m_mem[a]});
      end
      axi(1'b0, `CAL_ACC_OFS, 32'h0);
      check("acc_rd", r, {`CAL_RESP_OKAY, 24'h0, m_acc});
      axi(1'b0, `CAL_STATUS_OFS, 32'h0);
      check("status_rd", r, {`CAL_RESP_OKAY, 29'h0, m_fl});
      tally_and_finish();
   end
endmodule
`default_nettype wire
